// ---- verilog/usp_serial_port.sv ----
`timescale 1ns/10ps
// Operation
// - Bit 7 picks 8-bit framing at 0, 9-bit framing at 1.
// - Bit 6 always reads 1; writes to it are ignored.
// - 8-bit framing with filter set: receive done only when stop bit is 1.
// - 9-bit framing with filter set: receive done only when ninth bit is 1.
// - Receive enable at 0 blocks reception; at 1 allows it to start.
// - 9-bit framing sends the transmit ninth bit; 8-bit framing ignores it.
// - Receive ninth bit takes stop bit (8-bit) or ninth data bit (9-bit).
// - Transmit done sets when the stop bit begins after the data bits.
// - Receive done sets when an accepted frame's stop bit is sampled.
// - Hardware never clears either done flag; software writes them clear.
// - With interrupt enabled, either done flag raises the interrupt request.
// - Control register sits at address 0x98, page 0, bit addressable.
// - 8-bit frame: start, eight data bits LSB first, stop; ten bits.
// - 9-bit frame: start, eight data LSB first, ninth bit, stop; eleven.
// - Received byte loads only while receive done is 0; else lost.
// - Writing the data buffer starts a transmission.
module usp_serial_port (
  input  wire logic                  mclk,          // 25 MHz system clock
  input  wire logic                  rst_b,         // Asynchronous reset, active low
  input  wire usp_pkg::usp_sfr_req_t sfrReq,        // Register bus request
  output logic [7:0]                 sfrRdata,      // Read data, one cycle after read
  input  wire logic                  timerOverflow, // Reload timer overflow pulse
  input  wire logic                  intEnable,     // Serial interrupt enable
  input  wire logic                  rxLine,        // Serial receive line
  output logic                       txLine,        // Serial transmit line
  output logic                       irqReq,        // Interrupt request to CPU
  output logic                       txBufferReady  // Transmit buffer has room
);
  import usp_pkg::*;

  usp_state_t st;
  usp_state_t next_st;

  logic       pageHit;
  logic       ctrlWrite;
  logic       dataWrite;
  logic       ctrlRead;
  logic       dataRead;
  logic       ctrlBitWrite;
  logic [7:0] ctrlView;
  logic       txTick;
  logic       rxSample;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic       fifoOutReady;
  logic [7:0] fifoOutData;
  logic       mode9;
  logic       rxAccept;
  logic       rxNinthValue;
  logic       rxFall;
  logic       txLastBit;
  logic       rxLastBit;
  logic [7:0] ctrlBitSel;
  logic [7:0] ctrlSoft;

  // Address decode on page 0
  assign pageHit      = sfrReq.page == USP_SFR_PAGE;
  assign ctrlWrite    = pageHit && sfrReq.write && (sfrReq.addr == USP_CTRL_ADDR);
  assign dataWrite    = pageHit && sfrReq.write && (sfrReq.addr == USP_DATA_ADDR);
  assign ctrlRead     = pageHit && sfrReq.read && (sfrReq.addr == USP_CTRL_ADDR);
  assign dataRead     = pageHit && sfrReq.read && (sfrReq.addr == USP_DATA_ADDR);
  assign ctrlBitWrite = pageHit && sfrReq.bitWrite && (sfrReq.bitAddr[7:3] == USP_CTRL_BIT_BASE);

  // Control register as software sees it
  always_comb begin
    ctrlView                = st.ctrl;
    ctrlView[USP_BIT_SPARE] = 1'h1;
  end

  // Per-bit software update of the control register
  generate
    for (genvar g = 0; g < 8; g++) begin : gCtrlBit
      assign ctrlBitSel[g] = ctrlBitWrite && (sfrReq.bitAddr[2:0] == 3'(g));
      assign ctrlSoft[g]   = ctrlBitSel[g] ? sfrReq.bitValue : (ctrlWrite ? sfrReq.wdata[g] : st.ctrl[g]);
    end
  endgenerate

  // Baud ticks from the reload timer
  assign txTick   = timerOverflow && st.txHalf;
  assign rxSample = timerOverflow && st.rxPhase;

  // Frame length select
  assign mode9    = st.ctrl[USP_BIT_MODE];

  // Start edge and last data bit terms
  assign rxFall    = st.rxPrev && !rxLine;
  assign txLastBit = st.txCount == USP_LAST_DATA;
  assign rxLastBit = st.rxCount == USP_LAST_DATA;

  // Frame acceptance at stop-bit sampling
  assign rxNinthValue = mode9 ? st.rxNinth : rxLine;
  always_comb begin
    rxAccept = !st.ctrl[USP_BIT_RI];
    if (st.ctrl[USP_BIT_MCE]) begin
      if (mode9) begin
        rxAccept = rxAccept && st.rxNinth;
      end else begin
        rxAccept = rxAccept && rxLine;
      end
    end
  end

  // Transmitter takes a word only when idle
  assign fifoOutReady = st.txState == TX_IDLE;

  // Transmit word buffer
  usp_fifo #(
    .WIDTH(USP_DATA_WIDTH),
    .DEPTH(USP_FIFO_DEPTH)
  ) u_txFifo (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .inValid (dataWrite),
    .inReady (fifoInReady),
    .inData  (sfrReq.wdata),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData (fifoOutData)
  );

  // Next-state logic
  always_comb begin
    next_st = st;

    // Receive line history for start detection
    next_st.rxPrev = rxLine;

    // Software writes; a bit write wins for its bit
    next_st.ctrl                = ctrlSoft;
    next_st.ctrl[USP_BIT_SPARE] = 1'h1;

    // Register read data
    if (ctrlRead) begin
      next_st.rdData = ctrlView;
    end else if (dataRead) begin
      next_st.rdData = st.rxBuffer;
    end else if (sfrReq.read) begin
      next_st.rdData = USP_UNMAPPED;
    end

    // Transmit baud divider
    if (timerOverflow) begin
      next_st.txHalf = !st.txHalf;
    end

    // Transmitter
    unique case (st.txState)
      // Wait for a queued word
      TX_IDLE: begin
        if (fifoOutValid) begin
          next_st.txShift = fifoOutData;
          next_st.txState = TX_START;
        end
      end

      // Start bit on the next baud tick
      TX_START: begin
        if (txTick) begin
          next_st.txLine  = 1'h0;
          next_st.txCount = 3'h0;
          next_st.txState = TX_DATA;
        end
      end

      // Eight data bits, LSB first
      TX_DATA: begin
        if (txTick) begin
          next_st.txLine  = st.txShift[0];
          next_st.txShift = {1'h0, st.txShift[7:1]};
          next_st.txCount = st.txCount + 3'h1;
          if (txLastBit) begin
            next_st.txState = mode9 ? TX_NINTH : TX_STOP;
          end
        end
      end

      // Ninth bit from the control register
      TX_NINTH: begin
        if (txTick) begin
          next_st.txLine  = st.ctrl[USP_BIT_TB8];
          next_st.txState = TX_STOP;
        end
      end

      // Stop bit begins, transmit done set
      TX_STOP: begin
        if (txTick) begin
          next_st.txLine  = 1'h1;
          next_st.ctrl[USP_BIT_TI] = 1'h1;
          next_st.txState = TX_END;
        end
      end

      // Stop bit lasts one bit time
      TX_END: begin
        if (txTick) begin
          next_st.txState = TX_IDLE;
        end
      end

      // Unused codes return to an idle line
      default: begin
        next_st.txState = TX_IDLE;
        next_st.txLine  = 1'h1;
      end
    endcase

    // Receive bit-time phase
    if (timerOverflow && (st.rxState != RX_IDLE)) begin
      next_st.rxPhase = !st.rxPhase;
    end

    // Receiver
    unique case (st.rxState)
      // Falling edge starts a frame
      RX_IDLE: begin
        if (st.ctrl[USP_BIT_REN] && rxFall) begin
          next_st.rxPhase = 1'h1;
          next_st.rxState = RX_START;
        end
      end

      // Start bit must still be low
      RX_START: begin
        if (rxSample) begin
          next_st.rxCount = 3'h0;
          next_st.rxState = rxLine ? RX_IDLE : RX_DATA;
        end
      end

      // Eight data bits, LSB first
      RX_DATA: begin
        if (rxSample) begin
          next_st.rxShift = {rxLine, st.rxShift[7:1]};
          next_st.rxCount = st.rxCount + 3'h1;
          if (rxLastBit) begin
            next_st.rxState = mode9 ? RX_NINTH : RX_STOP;
          end
        end
      end

      // Ninth bit held for the stop sample
      RX_NINTH: begin
        if (rxSample) begin
          next_st.rxNinth = rxLine;
          next_st.rxState = RX_STOP;
        end
      end

      // Stop sample decides acceptance
      RX_STOP: begin
        if (rxSample) begin
          if (rxAccept) begin
            next_st.rxBuffer          = st.rxShift;
            next_st.ctrl[USP_BIT_RB8] = rxNinthValue;
            next_st.ctrl[USP_BIT_RI]  = 1'h1;
          end
          next_st.rxState = RX_IDLE;
        end
      end

      // Unused codes abandon the frame
      default: begin
        next_st.rxState = RX_IDLE;
        next_st.rxPhase = 1'h0;
      end
    endcase

    // Disabled receiver abandons any frame
    if (!st.ctrl[USP_BIT_REN]) begin
      next_st.rxState = RX_IDLE;
    end

    // Interrupt request from either done flag
    next_st.irq = intEnable && (next_st.ctrl[USP_BIT_TI] || next_st.ctrl[USP_BIT_RI]);

    // Transmit buffer room, one cycle late
    next_st.bufReady = fifoInReady;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st          <= '0;
      st.ctrl     <= USP_CTRL_RESET;
      st.rxBuffer <= USP_DATA_RESET;
      st.txState  <= TX_IDLE;
      st.rxState  <= RX_IDLE;
      // Line and edge history idle high
      st.txLine   <= 1'h1;
      st.rxPrev   <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign sfrRdata      = st.rdData;
  assign txLine        = st.txLine;
  assign irqReq        = st.irq;
  assign txBufferReady = st.bufReady;
endmodule

// ---- verilog/usp_pkg.sv ----
package usp_pkg;

  // Special-function register map
  localparam logic [7:0] USP_SFR_PAGE     = 8'h00;
  localparam logic [7:0] USP_CTRL_ADDR    = 8'h98;
  localparam logic [7:0] USP_DATA_ADDR    = 8'h99;
  localparam logic [4:0] USP_CTRL_BIT_BASE = 5'h13;
  localparam logic [7:0] USP_CTRL_RESET   = 8'h40;
  localparam logic [7:0] USP_DATA_RESET   = 8'h00;
  localparam logic [7:0] USP_UNMAPPED     = 8'h00;

  // Control register field positions
  localparam int USP_BIT_MODE  = 7;
  localparam int USP_BIT_SPARE = 6;
  localparam int USP_BIT_MCE   = 5;
  localparam int USP_BIT_REN   = 4;
  localparam int USP_BIT_TB8   = 3;
  localparam int USP_BIT_RB8   = 2;
  localparam int USP_BIT_TI    = 1;
  localparam int USP_BIT_RI    = 0;

  // Timing and framing
  localparam int         USP_OVF_PER_BIT  = 2;
  localparam logic [2:0] USP_LAST_DATA    = 3'h7;
  localparam int         USP_DATA_WIDTH   = 8;
  localparam int         USP_FIFO_DEPTH   = 32;

  // Register bus request from the CPU
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       write;
    logic       read;
    logic [7:0] wdata;
    logic       bitWrite;
    logic [7:0] bitAddr;
    logic       bitValue;
  } usp_sfr_req_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_END
  } usp_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
  } usp_rx_state_t;

  // Complete state of the serial port
  typedef struct packed {
    logic [7:0]    ctrl;
    logic [7:0]    rxBuffer;
    logic [7:0]    rdData;
    usp_tx_state_t txState;
    logic          txHalf;
    logic [7:0]    txShift;
    logic [2:0]    txCount;
    logic          txLine;
    usp_rx_state_t rxState;
    logic          rxPrev;
    logic          rxPhase;
    logic [7:0]    rxShift;
    logic [2:0]    rxCount;
    logic          rxNinth;
    logic          irq;
    logic          bufReady;
  } usp_state_t;

endpackage

// ---- verilog/usp_fifo.sv ----
`timescale 1ns/10ps
module usp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,     // System clock
  input  wire logic             rst_b,    // Asynchronous reset, active low
  input  wire logic             inValid,  // Write request
  output logic                  inReady,  // Room for a word
  input  wire logic [WIDTH-1:0] inData,   // Word to store
  output logic                  outValid, // Head word present
  input  wire logic             outReady, // Consumer takes head
  output logic [WIDTH-1:0]      outData   // Head word, registered
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

  typedef struct packed {
    logic [AW:0]      count;
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic             headValid;
    logic [WIDTH-1:0] head;
  } usp_fifo_state_t;

  usp_fifo_state_t st;
  usp_fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             refill;

  // Handshake terms
  assign inReady  = st.count != FULL_COUNT;
  assign push     = inValid && inReady;
  assign refill   = (st.count != '0) && (!st.headValid || outReady);
  assign outValid = st.headValid;
  assign outData  = st.head;

  // Pointer and head register update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wrPtr = st.wrPtr + 1'h1;
    end
    if (outReady && st.headValid) begin
      next_st.headValid = 1'h0;
    end
    if (refill) begin
      next_st.head      = mem[st.rdPtr];
      next_st.headValid = 1'h1;
      next_st.rdPtr     = st.rdPtr + 1'h1;
    end
    next_st.count = st.count + {{AW{1'h0}}, push} - {{AW{1'h0}}, refill};
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[st.wrPtr] <= inData;
    end
  end
endmodule

// ---- testbench/usp_serial_port_monitor.sv ----
`timescale 1ns/10ps
// Port checks of the serial port
module usp_serial_port_monitor
  import usp_pkg::*;
(
  input wire logic         mclk,          // Clock
  input wire logic         rst_b,         // Reset
  input wire usp_sfr_req_t sfrReq,        // Bus request
  input wire logic [7:0]   sfrRdata,      // Read data
  input wire logic         timerOverflow, // Overflow
  input wire logic         intEnable,     // Irq enable
  input wire logic         txLine,        // Tx line
  input wire logic         irqReq         // Irq out
);
  logic       txSeen;
  logic [1:0] ovfCnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Overflows since the tx line moved
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txSeen <= 1'h1;
      ovfCnt <= 2'h3;
    end else begin
      txSeen <= txLine;
      if (txLine != txSeen) ovfCnt <= {1'h0, timerOverflow};
      else if (timerOverflow && ovfCnt != 2'h3) ovfCnt <= ovfCnt + 2'h1;
    end
  end
  // Line timing
  property p_tx_tick;
    $changed(txLine) |-> $past(timerOverflow);
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("tx off tick");
  property p_bit_time;
    txLine != txSeen |-> ovfCnt >= 2'h2;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("short bit");
  property p_stop;
    $fell(txLine) |-> ##[1:88] txLine;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop bit");
  // Register reads
  property p_spare;
    sfrReq.read && sfrReq.page == USP_SFR_PAGE && sfrReq.addr == USP_CTRL_ADDR |=> sfrRdata[USP_BIT_SPARE];
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit low");
  property p_unmapped;
    sfrReq.read && (sfrReq.page != USP_SFR_PAGE || sfrReq.addr[7:1] != 7'h4c) |=> sfrRdata == USP_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rd_hold;
    !sfrReq.read |=> $stable(sfrRdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // Interrupt request
  property p_irq_en;
    irqReq |-> $past(intEnable);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while off");
  property p_irq_hold;
    $fell(irqReq) |-> !$past(intEnable) || $past(sfrReq.write) || $past(sfrReq.bitWrite);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag self clear");
endmodule

bind usp_serial_port usp_serial_port_monitor usp_serial_port_monitor_inst (
  .mclk, .rst_b, .sfrReq, .sfrRdata, .timerOverflow, .intEnable, .txLine, .irqReq);

// ---- testbench/usp_remote.sv ----
`timescale 1ns/10ps
// Far-end transceiver on the two lines
module usp_remote (
  input  wire logic mclk,          // Clock
  input  wire logic timerOverflow, // Overflow
  input  wire logic txLine,        // From port
  output logic      rxLine         // Into port, idle high
);
  logic [9:0] txq[$];
  logic [9:0] b;
  initial rxLine = 1'h1;
  // Next overflow, then off the edge
  task automatic ovf();
    do @(posedge mclk); while (timerOverflow !== 1'h1);
    @(negedge mclk);
  endtask
  // Start, data LSB first, ninth or stop, stop
  task automatic send(input logic [7:0] d, input logic last, input logic nine);
    logic [10:0] f;
    f = {1'h1, last, d, 1'h0};
    ovf();
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxLine = f[i];
      ovf();
      ovf();
    end
    rxLine = 1'h1;
    ovf();
    ovf();
  endtask
  // Capture start, eight data and bit nine mid-bit
  initial forever begin
    @(negedge txLine);
    ovf();
    b[0] = txLine;
    for (int i = 1; i < 10; i++) begin
      ovf();
      ovf();
      b[i] = txLine;
    end
    txq.push_back(b);
    if (txLine !== 1'h1) @(posedge txLine);
  end
endmodule

// ---- testbench/usp_serial_port_bench.sv ----
`timescale 1ns/10ps
// Serial port control bench
module usp_serial_port_bench;
  import usp_pkg::*;
  logic         mclk = 1'h0;
  logic         rst_b = 1'h0;
  usp_sfr_req_t sfrReq = '0;
  logic         timerOverflow = 1'h0;
  logic         intEnable = 1'h0;
  logic [7:0]   sfrRdata, d, prev;
  logic         rxLine, txLine, irqReq, txBufferReady, acc;
  logic [1:0]   div = 2'h0;
  logic [31:0]  seed = 32'hf6a07c09;
  logic [9:0]   b;
  logic [7:0]   expq[$];
  int           errorCnt = 0;
  int           nCompared = 0;
  int           cycles = 0;

  usp_serial_port usp_serial_port_inst (.mclk, .rst_b, .sfrReq, .sfrRdata, .timerOverflow,
    .intEnable, .rxLine, .txLine, .irqReq, .txBufferReady);
  usp_remote usp_remote_inst (.mclk, .timerOverflow, .txLine, .rxLine);

  initial forever #20 mclk = ~mclk;
  // Overflow every fourth cycle, watchdog
  always @(negedge mclk) begin
    div <= div + 2'h1;
    timerOverflow <= div == 2'h3;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      endOfTest();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ctrlExp(input logic m, f, r, t, input logic [2:0] lo);
    return {m, 1'h1, f, r, t, lo};
  endfunction
  task automatic rnd();
    seed = lfsr(seed);
    d = seed[7:0];
  endtask
  // Request held over one rising edge
  task automatic bus(input logic [2:0] k, input logic [7:0] pg, a, v);
    @(negedge mclk);
    sfrReq = '{pg, a, k[1], k[0], v, k[2], a, v[0]};
    @(negedge mclk);
    sfrReq = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(3'h1, 8'h0, a, 8'h0);
  endtask
  task automatic wr(input logic [7:0] a, v);
    bus(3'h2, 8'h0, a, v);
  endtask
  task automatic check(input logic [7:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic getTx();
    for (int w = 0; w < 400 && usp_remote_inst.txq.size() == 0; w++) @(negedge mclk);
    b = usp_remote_inst.txq.size() ? usp_remote_inst.txq.pop_front() : 'x;
  endtask
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk) rst_b = 1'h1;
    rd(USP_CTRL_ADDR);
    check(sfrRdata, USP_CTRL_RESET);
    wr(USP_CTRL_ADDR, 8'h00);
    bus(3'h4, 8'h0, 8'h9c, 8'h1);
    bus(3'h4, 8'h0, 8'h9e, 8'h0);
    rd(USP_CTRL_ADDR);
    check(sfrRdata, ctrlExp(1'h0, 1'h0, 1'h1, 1'h0, 3'h0));
    bus(3'h1, 8'h1, USP_CTRL_ADDR, 8'h0);
    check(sfrRdata, USP_UNMAPPED);
    rd(8'h9a);
    check(sfrRdata, USP_UNMAPPED);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      rnd();
      intEnable = seed[8];
      wr(USP_CTRL_ADDR, ctrlExp(i[1], 1'h0, 1'h0, i[0], 3'h0));
      wr(USP_DATA_ADDR, d);
      getTx();
      check({b[0], 7'h0}, 8'h00);
      check(b[8:1], d);
      check({7'h0, b[9]}, {7'h0, i[1] ? i[0] : 1'h1});
      repeat (12) @(negedge mclk);
      rd(USP_CTRL_ADDR);
      check(sfrRdata, ctrlExp(i[1], 1'h0, 1'h0, i[0], 3'h2));
      check({7'h0, irqReq}, {7'h0, intEnable});
      bus(3'h4, 8'h0, 8'h99, 8'h0);
      check({7'h0, irqReq}, 8'h00);
    end
    $display("transmit done");
    prev = USP_DATA_RESET;
    for (int i = 0; i < 8; i++) begin
      rnd();
      acc = !i[1] || i[2];
      wr(USP_CTRL_ADDR, ctrlExp(i[0], i[1], 1'h1, 1'h0, 3'h0));
      usp_remote_inst.send(d, i[2], i[0]);
      if (acc) prev = d;
      rd(USP_CTRL_ADDR);
      check(sfrRdata, ctrlExp(i[0], i[1], 1'h1, 1'h0, {acc & i[2], 1'h0, acc}));
      check({7'h0, irqReq}, {7'h0, intEnable & acc});
      rd(USP_DATA_ADDR);
      check(sfrRdata, prev);
    end
    d = ~prev;
    usp_remote_inst.send(d, 1'h1, 1'h1);
    rd(USP_DATA_ADDR);
    check(sfrRdata, prev);
    wr(USP_CTRL_ADDR, 8'h00);
    usp_remote_inst.send(d, 1'h1, 1'h0);
    rd(USP_CTRL_ADDR);
    check(sfrRdata, USP_CTRL_RESET);
    $display("receive done");
    while (txBufferReady === 1'h1 && expq.size() < 40) begin
      rnd();
      expq.push_back(d);
      wr(USP_DATA_ADDR, d);
      @(negedge mclk);
    end
    check({7'h0, txBufferReady}, 8'h00);
    while (expq.size() > 0) begin
      getTx();
      check(b[8:1], expq.pop_front());
    end
    $display("queue done");
    endOfTest();
  end
endmodule
